// ### rtl/isp_pkg.sv
// Shared constants and types for the I2C register slave port.
`default_nettype none
package isp_pkg;
    // Core clock rate, used to turn times into cycle counts.
    localparam int MCLK_FREQ_MHZ = 200;
    // Widest spike that the input filters swallow in each speed mode.
    localparam int T_SPIKE_FS_NS = 50;
    localparam int T_SPIKE_HS_NS = 10;
    // Filter lengths in cycles, rounded up so that a full spike is covered.
    localparam int SPIKE_FS_CYC = (T_SPIKE_FS_NS * MCLK_FREQ_MHZ + 999) / 1000;
    localparam int SPIKE_HS_CYC = (T_SPIKE_HS_NS * MCLK_FREQ_MHZ + 999) / 1000;
    localparam int FLT_CNT_W = 4;
    localparam logic [FLT_CNT_W-1:0] FLT_FS_LAST = FLT_CNT_W'(SPIKE_FS_CYC - 1);
    localparam logic [FLT_CNT_W-1:0] FLT_HS_LAST = FLT_CNT_W'(SPIKE_HS_CYC - 1);
    // Fixed upper address bits used when the select pin is low.
    localparam logic [3:0] ADDR_FIXED_HI = 4'h5;
    // A master code byte carries this pattern in its five upper bits.
    localparam logic [4:0] MCODE_PREFIX = 5'h01;
    // Index of the last bit of a byte.
    localparam logic [2:0] BIT_LAST = 3'h7;
    // Cycles between reset release and the strap capture.
    localparam logic [1:0] STRAP_WAIT = 2'h3;
    // Idle level of both bus lines.
    localparam logic [1:0] LINE_IDLE = 2'h3;
    // Byte engine states.
    typedef enum logic [2:0] {
        ST_IDLE, ST_RX, ST_ACK, ST_TX, ST_MACK, ST_IGNORE
    } isp_state_t;
    // Meaning of the next byte received.
    typedef enum logic [1:0] {
        PH_ADDR, PH_PTR, PH_DATA
    } isp_phase_t;
endpackage
`default_nettype wire

// ### rtl/isp_link_if.sv
// Internal carrier between the line filter, strap latch and byte engine.
`default_nettype none
interface isp_link_if;
    logic       scl;      // Filtered clock level.
    logic       sda;      // Filtered data level.
    logic       scl_rise; // One-cycle pulse on a filtered clock rise.
    logic       scl_fall; // One-cycle pulse on a filtered clock fall.
    logic       start;    // Start or repeated start seen.
    logic       stop;     // Stop seen.
    logic       hs;       // High-speed settings in force.
    logic [6:0] own_addr; // Latched slave address.
    logic       addr_ok;  // Address has been latched.
    modport line  (output scl, sda, scl_rise, scl_fall, start, stop, input hs);
    modport strap (output own_addr, addr_ok);
    modport core  (input scl, sda, scl_rise, scl_fall, start, stop, own_addr, addr_ok, output hs);
endinterface
`default_nettype wire

// ### rtl/isp_line_filter.sv
// Synchroniser, spike filter and start/stop detector for the two bus lines.
`default_nettype none
module isp_line_filter
    import isp_pkg::*;
(
    // Clock and reset.
    input  wire logic clk,
    input  wire logic rst,
    // Raw bus lines.
    input  wire logic scl_pin,
    input  wire logic sda_pin,
    // Filtered events.
    isp_link_if.line  lnk
);
    logic [1:0]                s1_q;   // First stage, read only by the second.
    logic [1:0]                s2_q;   // Second stage.
    logic [1:0]                s3_q;   // Third stage.
    logic [1:0]                flt_q;  // Accepted levels, bit 0 clock, bit 1 data.
    logic [1:0]                prev_q; // Accepted levels one cycle back.
    logic [1:0][FLT_CNT_W-1:0] cnt_q;  // Stable-time counters.
    wire  [FLT_CNT_W-1:0]      last;   // Filter length for the current mode.

    // High-speed mode shortens the filter, so it also admits shorter spikes.
    assign last = lnk.hs ? FLT_HS_LAST : FLT_FS_LAST;

    // Three-stage synchroniser; lines idle high.
    always_ff @(posedge clk) begin
        if (rst) begin
            s1_q <= LINE_IDLE;
            s2_q <= LINE_IDLE;
            s3_q <= LINE_IDLE;
        end else begin
            s1_q <= {sda_pin, scl_pin};
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    // A new level is taken only after it stood, with stages two and three agreeing, for the whole filter time.
    always_ff @(posedge clk) begin
        if (rst) begin
            flt_q  <= LINE_IDLE;
            prev_q <= LINE_IDLE;
            cnt_q  <= '0;
        end else begin
            prev_q <= flt_q;
            for (int i = 0; i < 2; i++) begin
                // A mode switch can drop the limit below a running count, so the compare is not exact.
                if (s2_q[i] != s3_q[i] || s3_q[i] == flt_q[i]) begin
                    cnt_q[i] <= '0;
                end else if (cnt_q[i] >= last) begin
                    flt_q[i] <= s3_q[i];
                    cnt_q[i] <= '0;
                end else begin
                    cnt_q[i] <= cnt_q[i] + FLT_CNT_W'(1);
                end
            end
        end
    end

    // Edge and condition decode from the accepted levels.
    assign lnk.scl      = flt_q[0];
    assign lnk.sda      = flt_q[1];
    assign lnk.scl_rise = flt_q[0] & ~prev_q[0];
    assign lnk.scl_fall = ~flt_q[0] & prev_q[0];
    assign lnk.start    = flt_q[0] & prev_q[0] & prev_q[1] & ~flt_q[1];
    assign lnk.stop     = flt_q[0] & prev_q[0] & ~prev_q[1] & flt_q[1];
endmodule
`default_nettype wire

// ### rtl/isp_strap_latch.sv
// Captures the slave address straps once after reset release.
`default_nettype none
module isp_strap_latch
    import isp_pkg::*;
(
    // Clock and reset.
    input  wire logic       clk,
    input  wire logic       rst,
    // Strap pins.
    input  wire logic       sel_pin,
    input  wire logic [5:0] addr_pins,
    // Latched address.
    isp_link_if.strap       lnk
);
    logic [6:0] s1_q;   // First stage, read only by the second.
    logic [6:0] s2_q;   // Second stage.
    logic [6:0] s3_q;   // Third stage.
    logic [1:0] wait_q; // Cycles since reset release.
    logic       done_q; // Address has been taken.
    logic [6:0] addr_q; // Latched address.
    wire        take;   // Capture strobe.
    wire  [6:0] addr_d; // Address built from the straps.

    // Select low keeps four fixed upper bits; select high uses six pins and a zero MSB.
    assign addr_d = s3_q[6] ? {1'b0, s3_q[5:0]} : {ADDR_FIXED_HI, s3_q[2:0]};
    assign take   = !done_q && wait_q == STRAP_WAIT && s2_q == s3_q;

    // Capture only once; pin changes afterwards are ignored until the next reset.
    always_ff @(posedge clk) begin
        if (rst) begin
            s1_q   <= '0;
            s2_q   <= '0;
            s3_q   <= '0;
            wait_q <= '0;
            done_q <= 1'b0;
            addr_q <= '0;
        end else begin
            s1_q <= {sel_pin, addr_pins};
            s2_q <= s1_q;
            s3_q <= s2_q;
            if (wait_q != STRAP_WAIT) begin
                wait_q <= wait_q + 2'h1;
            end
            if (take) begin
                done_q <= 1'b1;
                addr_q <= addr_d;
            end
        end
    end

    assign lnk.own_addr = addr_q;
    assign lnk.addr_ok  = done_q;
endmodule
`default_nettype wire

// ### rtl/isp_slave.sv
// I2C slave port giving a host read and write access to internal registers.
// Operation
// - Bytes travel MSB first, then acknowledge slot.
// - Sender releases, receiver holds SDA low.
// - Master nack ends read; device releases SDA.
// - No limit on bytes per transfer.
// - First byte after start selects the slave.
// - Straps sampled once at reset release.
// - Select low: upper bits fixed 0101b.
// - Select high: six pin bits, MSB zero.
// - Write: address, pointer, data to one register.
// - Read frame returns pointed register every byte.
// - Start, master code, nack enter high speed.
// - High speed holds across repeated starts.
// - Only stop leaves high-speed mode.
// - Fast mode after reset.
// - Master code switches the input filters.
// - Force bit gives permanent high speed.
// - Without master code stay in fast mode.
// - Slave only; never drives clock.
// - Detect start and stop; restart acts as start.
`default_nettype none
module isp_slave
    import isp_pkg::*;
(
    // Clock and reset.
    input  wire logic       MCLK,
    input  wire logic       RST,
    // Bus lines; the clock is only ever an input.
    input  wire logic       SCL,
    input  wire logic       SDA_I,
    output logic            SDA_O,
    output logic            SDA_OE,
    // Address straps.
    input  wire logic       ADDRESS_SELECT_PIN,
    input  wire logic [5:0] ADDR_PIN,
    // Mode control and status.
    input  wire logic       FORCE_HIGH_SPEED,
    output logic            HS_MODE,
    // Internal register port.
    output logic [7:0]      REG_ADDR,
    output logic [7:0]      REG_WDATA,
    output logic            REG_WE,
    output logic            REG_RE,
    input  wire logic [7:0] REG_RDATA
);
    isp_link_if lnk ();

    isp_state_t st_q;        // Byte engine state.
    isp_state_t st_d;
    isp_phase_t ph_q;        // Meaning of the next received byte.
    isp_phase_t ph_d;
    logic [2:0] bit_cnt_q;   // Bit index within a byte.
    logic [2:0] bit_cnt_d;
    logic [7:0] shift_q;     // Receive or transmit shifter.
    logic [7:0] shift_d;
    logic       slot_q;      // Acknowledge bit is on the bus.
    logic       slot_d;
    logic       ack_q;       // This byte is acknowledged.
    logic       ack_d;
    logic       rw_q;        // Frame direction, one for read.
    logic       rw_d;
    logic       mcode_q;     // Byte just received was a master code.
    logic       mcode_d;
    logic       hs_q;        // High-speed mode entered by master code.
    logic       hs_d;
    logic       oe_q;        // Pulling SDA low.
    logic       oe_d;
    logic [7:0] ptr_q;       // Register pointer.
    logic [7:0] ptr_d;
    logic [7:0] wdata_q;     // Write data to the register file.
    logic [7:0] wdata_d;
    logic       we_q;        // Write strobe.
    logic       we_d;
    logic       re_q;        // Read strobe.
    logic       re_d;

    wire  [7:0] rx_byte;     // Byte complete at this clock rise.
    wire        last_bit;    // Current bit is the eighth.
    wire        addr_hit;    // Address byte names this device.
    wire        is_mcode;    // Address byte is a master code.
    wire        load_tx;     // Fetch and present the next read byte.

    // Line conditioning and edge detection.
    isp_line_filter u_line (
        .clk     (MCLK),
        .rst     (RST),
        .scl_pin (SCL),
        .sda_pin (SDA_I),
        .lnk     (lnk)
    );

    // Slave address capture.
    isp_strap_latch u_strap (
        .clk       (MCLK),
        .rst       (RST),
        .sel_pin   (ADDRESS_SELECT_PIN),
        .addr_pins (ADDR_PIN),
        .lnk       (lnk)
    );

    // Bits are shifted in at the bottom and move up, so the first bit ends up as MSB.
    assign rx_byte  = {shift_q[6:0], lnk.sda};
    assign last_bit = bit_cnt_q == BIT_LAST;
    // Before the straps are taken nothing matches, so an early frame is ignored.
    assign addr_hit = lnk.addr_ok && rx_byte[7:1] == lnk.own_addr;
    // A master code is only meaningful while still in fast mode.
    assign is_mcode = rx_byte[7:3] == MCODE_PREFIX && !HS_MODE;
    // Read bytes are fetched at the fall that ends the address ack or a master ack.
    assign load_tx  = lnk.scl_fall && slot_q &&
                      ((st_q == ST_ACK && ack_q && rw_q) || st_q == ST_MACK);

    // Next-state logic of the byte engine.
    always_comb begin
        st_d      = st_q;
        ph_d      = ph_q;
        bit_cnt_d = bit_cnt_q;
        shift_d   = shift_q;
        slot_d    = slot_q;
        ack_d     = ack_q;
        rw_d      = rw_q;
        mcode_d   = mcode_q;
        hs_d      = hs_q;
        oe_d      = oe_q;
        ptr_d     = ptr_q;
        wdata_d   = wdata_q;
        we_d      = 1'b0;
        re_d      = 1'b0;
        if (lnk.start) begin
            // Start and repeated start rearm address reception; speed mode is kept.
            st_d      = ST_RX;
            ph_d      = PH_ADDR;
            bit_cnt_d = '0;
            slot_d    = 1'b0;
            mcode_d   = 1'b0;
            oe_d      = 1'b0;
        end else if (lnk.stop) begin
            // Stop is the only way back to fast mode.
            st_d   = ST_IDLE;
            slot_d = 1'b0;
            oe_d   = 1'b0;
            hs_d   = 1'b0;
        end else if (load_tx) begin
            // Present the MSB of the pointed register on the same fall.
            st_d      = ST_TX;
            slot_d    = 1'b0;
            bit_cnt_d = '0;
            shift_d   = REG_RDATA;
            oe_d      = ~REG_RDATA[7];
            re_d      = 1'b1;
        end else begin
            case (st_q)
                ST_RX: begin
                    // Sample on each clock rise; decide the byte on the eighth.
                    if (lnk.scl_rise) begin
                        shift_d   = rx_byte;
                        bit_cnt_d = bit_cnt_q + 3'h1;
                        if (last_bit) begin
                            st_d = ST_ACK;
                            case (ph_q)
                                PH_ADDR: begin
                                    if (is_mcode) begin
                                        // Nobody acknowledges a master code.
                                        mcode_d = 1'b1;
                                        ack_d   = 1'b0;
                                    end else if (addr_hit) begin
                                        ack_d = 1'b1;
                                        rw_d  = rx_byte[0];
                                        ph_d  = PH_PTR;
                                    end else begin
                                        // Not for us: stay off the line until a condition.
                                        st_d  = ST_IGNORE;
                                        ack_d = 1'b0;
                                    end
                                end
                                PH_PTR: begin
                                    ptr_d = rx_byte;
                                    ack_d = 1'b1;
                                    ph_d  = PH_DATA;
                                end
                                default: begin
                                    // Every data byte goes to the same register.
                                    wdata_d = rx_byte;
                                    we_d    = 1'b1;
                                    ack_d   = 1'b1;
                                end
                            endcase
                        end
                    end
                end
                ST_ACK: begin
                    if (lnk.scl_fall && !slot_q) begin
                        // Receiver pulls low for the whole high phase of the ack pulse.
                        oe_d   = ack_q;
                        slot_d = 1'b1;
                    end else if (lnk.scl_rise && slot_q && mcode_q && lnk.sda) begin
                        // Master code followed by a not-acknowledge.
                        hs_d = 1'b1;
                    end else if (lnk.scl_fall && slot_q) begin
                        slot_d    = 1'b0;
                        oe_d      = 1'b0;
                        bit_cnt_d = '0;
                        // No byte count limit: loop back for another byte.
                        st_d      = ack_q ? ST_RX : ST_IGNORE;
                    end
                end
                ST_TX: begin
                    // Shift out on each clock fall; release for the master's ack.
                    if (lnk.scl_fall) begin
                        if (last_bit) begin
                            oe_d = 1'b0;
                            st_d = ST_MACK;
                        end else begin
                            shift_d   = {shift_q[6:0], 1'b0};
                            oe_d      = ~shift_q[6];
                            bit_cnt_d = bit_cnt_q + 3'h1;
                        end
                    end
                end
                ST_MACK: begin
                    // Low means another byte; high ends the read and we let go.
                    if (lnk.scl_rise) begin
                        if (lnk.sda) begin
                            st_d = ST_IGNORE;
                        end else begin
                            slot_d = 1'b1;
                        end
                    end
                end
                default: begin
                    // Idle and ignore wait for a condition with SDA released.
                    oe_d = 1'b0;
                end
            endcase
        end
    end

    // Engine registers.
    always_ff @(posedge MCLK) begin
        if (RST) begin
            st_q      <= ST_IDLE;
            ph_q      <= PH_ADDR;
            bit_cnt_q <= '0;
            shift_q   <= '0;
            slot_q    <= 1'b0;
            ack_q     <= 1'b0;
            rw_q      <= 1'b0;
            mcode_q   <= 1'b0;
            hs_q      <= 1'b0;
            oe_q      <= 1'b0;
        end else begin
            st_q      <= st_d;
            ph_q      <= ph_d;
            bit_cnt_q <= bit_cnt_d;
            shift_q   <= shift_d;
            slot_q    <= slot_d;
            ack_q     <= ack_d;
            rw_q      <= rw_d;
            mcode_q   <= mcode_d;
            hs_q      <= hs_d;
            oe_q      <= oe_d;
        end
    end

    // Register port registers.
    always_ff @(posedge MCLK) begin
        if (RST) begin
            ptr_q   <= '0;
            wdata_q <= '0;
            we_q    <= 1'b0;
            re_q    <= 1'b0;
        end else begin
            ptr_q   <= ptr_d;
            wdata_q <= wdata_d;
            we_q    <= we_d;
            re_q    <= re_d;
        end
    end

    // The force bit skips the master code; only safe on a point-to-point bus.
    assign HS_MODE   = hs_q | FORCE_HIGH_SPEED;
    assign lnk.hs    = HS_MODE;
    // Open drain: the port only ever pulls data low and never touches the clock.
    assign SDA_O     = 1'b0;
    assign SDA_OE    = oe_q;
    assign REG_ADDR  = ptr_q;
    assign REG_WDATA = wdata_q;
    assign REG_WE    = we_q;
    assign REG_RE    = re_q;

    // Checks on the engine, all in the core clock domain.
    default clocking cb @(posedge MCLK);
    endclocking
    default disable iff (RST);

    sequence s_byte_in;
        st_q == ST_RX && lnk.scl_rise && last_bit && !lnk.start && !lnk.stop;
    endsequence

    sequence s_master_nack;
        st_q == ST_MACK && lnk.scl_rise && lnk.sda && !lnk.start && !lnk.stop;
    endsequence

    a_oe_on_fall:
    assert property ($rose(SDA_OE) |-> $past(lnk.scl_fall))
        else $error("SDA drive began away from a clock fall");

    a_ignore_quiet:
    assert property (st_q == ST_IGNORE |-> !SDA_OE)
        else $error("SDA driven while ignoring the bus");

    a_addr_miss:
    assert property (s_byte_in ##0 (ph_q == PH_ADDR && !addr_hit && !is_mcode) |=> st_q == ST_IGNORE)
        else $error("Unmatched address was not ignored");

    a_write_data:
    assert property (s_byte_in ##0 (ph_q == PH_DATA) |=> REG_WE && REG_WDATA == $past(rx_byte) ##1 !REG_WE)
        else $error("Write byte not passed to the register port");

    a_read_strobe:
    assert property (REG_RE |-> rw_q && st_q == ST_TX && bit_cnt_q == 3'h0)
        else $error("Read strobe outside a read frame");

    a_nack_release:
    assert property (s_master_nack |=> st_q == ST_IGNORE && !SDA_OE)
        else $error("SDA not released after master nack");

    a_hs_hold:
    assert property (hs_q && !lnk.stop |=> hs_q)
        else $error("High-speed mode left without a stop");

    a_hs_entry:
    assert property ($rose(hs_q) |-> $past(mcode_q && st_q == ST_ACK && lnk.sda))
        else $error("High-speed mode entered without master code");

    a_start_rearm:
    assert property (lnk.start |=> st_q == ST_RX && bit_cnt_q == 3'h0 && !SDA_OE)
        else $error("Start did not rearm address reception");

    a_msb_first:
    assert property (st_q == ST_TX && lnk.scl_fall && !last_bit && !lnk.start && !lnk.stop
                     |=> SDA_OE == !$past(shift_q[6]))
        else $error("Transmit bit order wrong");

    a_reset_fast:
    assert property ($past(RST) |-> !hs_q)
        else $error("Not in fast mode after reset");
endmodule
`default_nettype wire

// ### bench/isp_master.sv
// Bus master model that clocks frames onto the two-wire link.
`default_nettype none
module isp_master (
    // Wire levels; a one on sda_drv releases the line.
    output logic      scl,
    output logic      sda_drv,
    input  wire logic sda
);
    timeunit 1ns;
    timeprecision 100ps;
    realtime hp = 500.0; // Half bit time; fast mode needs long phases.
    initial begin
        scl = 1'b1;
        sda_drv = 1'b1;
    end
    // Start or repeated start: data falls while the clock is high.
    task automatic start_c();
        #(hp/4) sda_drv = 1'b1;
        #(hp*3/4) scl = 1'b1;
        #(hp) sda_drv = 1'b0;
        #(hp) scl = 1'b0;
    endtask
    // Stop: data rises while the clock is high, then the bus idles.
    task automatic stop_c();
        #(hp/4) sda_drv = 1'b0;
        #(hp*3/4) scl = 1'b1;
        #(hp) sda_drv = 1'b1;
        #(hp);
    endtask
    // Eight bits MSB first and the acknowledge slot; data changes well after a fall.
    task automatic xfer(input logic [8:0] tx, output logic [8:0] rx);
        for (int i = 8; i >= 0; i--) begin
            #(hp/4) sda_drv = tx[i];
            #(hp*3/4) scl = 1'b1;
            #(hp) rx[i] = sda;
            scl = 1'b0;
        end
    endtask
endmodule
`default_nettype wire

// ### bench/isp_slave_tb.sv
// Self-checking bench for the two-wire register slave port.
`default_nettype none
module isp_slave_tb
    import isp_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic       mclk = 1'b0, rst = 1'b1, sel = 1'b0, force_hs = 1'b0;
    logic [5:0] adr = 6'h3b;  // Straps; low select uses only the three low bits.
    logic       scl, sda_drv, sda_o, sda_oe, hs, reg_we, reg_re;
    logic [7:0] reg_addr, reg_wdata, regs [256];
    logic [8:0] rx;
    logic [6:0] own;          // Address the port should answer to.
    wire  logic sda_line;
    int         fail_count = 0, total_checks = 0, we_n = 0, re_n = 0;
    // Open-drain wire with a pull-up: low if either party pulls.
    assign sda_line = sda_drv & (sda_oe ? sda_o : 1'b1);
    initial forever #2.5 mclk = ~mclk;
    // Register file behind the port; the read value is always valid.
    always @(posedge mclk) begin
        if (reg_we === 1'b1) begin
            regs[reg_addr] <= reg_wdata;
            we_n++;
        end
        if (reg_re === 1'b1) re_n++;
    end
    isp_master u_isp_master (.scl(scl), .sda_drv(sda_drv), .sda(sda_line));
    isp_slave u_isp_slave (.MCLK(mclk), .RST(rst), .SCL(scl), .SDA_I(sda_line), .SDA_O(sda_o), .SDA_OE(sda_oe),
        .ADDRESS_SELECT_PIN(sel), .ADDR_PIN(adr), .FORCE_HIGH_SPEED(force_hs), .HS_MODE(hs),
        .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata), .REG_WE(reg_we), .REG_RE(reg_re),
        .REG_RDATA(regs[reg_addr]));
    task automatic chk(input logic [8:0] seen, input logic [8:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic test_done();
        $display("checks=%0d mismatches=%0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // Reset is held for twelve cycles; straps must already be stable.
    task automatic do_reset();
        @(posedge mclk) #1 rst = 1'b1;
        repeat (12) @(posedge mclk);
        #1 rst = 1'b0;
        repeat (20) @(posedge mclk);
        #1;
    endtask
    // One written byte and the acknowledge that comes back.
    task automatic send(input logic [7:0] b, input logic ack);
        u_isp_master.xfer({b, 1'b1}, rx);
        chk({8'h00, rx[0]}, {8'h00, ack});
    endtask
    // Pointer then three data bytes, all landing on one register.
    task automatic sc_write();
        we_n = 0;
        u_isp_master.start_c();
        send({own, 1'b0}, 1'b0);
        send(8'h3c, 1'b0);
        for (int i = 0; i < 3; i++) send(8'ha5 ^ 8'(i), 1'b0);
        u_isp_master.stop_c();
        chk({1'b0, regs[8'h3c]}, 9'h0a7);
        chk(9'(we_n), 9'h003);
    endtask
    // Pointer write, restart, three reads of the same register ending in a nack.
    task automatic sc_read();
        re_n = 0;
        regs[8'h10] = 8'h96;
        u_isp_master.start_c();
        send({own, 1'b0}, 1'b0);
        send(8'h10, 1'b0);
        u_isp_master.start_c();
        send({own, 1'b1}, 1'b0);
        for (int i = 0; i < 3; i++) begin
            u_isp_master.xfer({8'hff, i == 2}, rx);
            chk({1'b0, rx[8:1]}, 9'h096);
        end
        chk({8'h00, rx[0]}, 9'h001);
        u_isp_master.stop_c();
        chk(9'(re_n), 9'h003);
    endtask
    // A foreign address gets no acknowledge and writes nothing.
    task automatic sc_foreign();
        we_n = 0;
        u_isp_master.start_c();
        send({own ^ 7'h01, 1'b0}, 1'b1);
        send(8'h00, 1'b1);
        u_isp_master.stop_c();
        chk(9'(we_n), 9'h000);
    endtask
    // Master code, restarts at high speed, then a stop drops back.
    task automatic sc_hs();
        chk(9'(hs), 9'h000);
        u_isp_master.start_c();
        send(8'h0b, 1'b1);
        chk(9'(hs), 9'h001);
        u_isp_master.hp = 62.5;
        u_isp_master.start_c();
        send({own, 1'b0}, 1'b0);
        u_isp_master.start_c();
        send({own, 1'b0}, 1'b0);
        chk(9'(hs), 9'h001);
        u_isp_master.stop_c();
        repeat (20) @(posedge mclk);
        #1 chk(9'(hs), 9'h000);
        u_isp_master.hp = 500.0;
    endtask
    // Forced high speed works without any master code.
    task automatic sc_force();
        @(posedge mclk) #1 force_hs = 1'b1;
        u_isp_master.hp = 62.5;
        u_isp_master.start_c();
        send({own, 1'b0}, 1'b0);
        u_isp_master.stop_c();
        chk(9'(hs), 9'h001);
        @(posedge mclk) #1 force_hs = 1'b0;
        u_isp_master.hp = 500.0;
    endtask
    // Select high: six strap bits, top address bit always zero.
    task automatic sc_sel_high();
        sel = 1'b1;
        adr = 6'h2a;
        do_reset();
        chk(9'(hs), 9'h000);
        own = 7'h2a;
        adr = 6'h15; // Ignored until the next reset.
        u_isp_master.start_c();
        send(8'hd4, 1'b1);
        u_isp_master.start_c();
        send({own, 1'b0}, 1'b0);
        u_isp_master.stop_c();
    endtask
    // Watchdog: the whole sequence needs under a fifth of a millisecond.
    initial begin
        #400000;
        fail_count++;
        test_done();
    end
    initial begin
        do_reset();
        own = {ADDR_FIXED_HI, 3'h3};
        adr = 6'h04; // Changes after the latch must not move the address.
        sc_write();
        sc_read();
        sc_foreign();
        sc_hs();
        sc_force();
        sc_sel_high();
        test_done();
    end
endmodule
`default_nettype wire
